// ---- design/jlr_regs.sv ----
// Device identifier, frame-end comma select and link status registers.
// Assumes an APB master on pclk and link status levels from another domain.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns

// Functional notes
// - The programmed identifier goes into the second multiframe lane configuration data.
// - Link A sends the identifier and link B sends the identifier plus one.
// - Identifier bit 0 is ignored on write and reads as zero.
// - An odd identifier write is stored as the next lower even value.
// - Frame-end select 0 is K28.7, 1 is K28.1, 2 is K28.5 and 3 is reserved.
// - The frame-end choice applies only to 8b/10b modes, never 64b/66b.
// - The chosen comma is substituted opportunistically at frame ends.
// - Status bit 6 reads high while the link is up.
// - Status bit 5 reads 0 while SYNC is requested and 1 otherwise.
// - Status bit 4 is set on any SYSREF realignment and cleared by writing 1.
// - Status bit 3 is set by the first SYSREF after enabling and cleared by writing 1.
// - Status bit 2 reads high while the serializer PLL is locked.
module jlr_regs
	import jlr_pkg::*;
(
	input wire logic pclk, // APB clock, 100 MHz.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic clk_en, // Clock enable; low freezes all state.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [JLR_ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	input wire logic [3:0] pstrb, // APB byte strobes.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped address.
	input wire jlr_link_in_type link_in, // Link status levels, asynchronous.
	output jlr_link_out_type link_out // Settings toward the link logic.
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] device_id;
		logic [1:0] frame_end_sel;
		logic [1:0] power_down;
		logic [1:0] link_ctrl;
		logic realigned;
		logic multiframe_phase_set_flag;
		logic armed;
		logic sysref_prev;
		logic realign_prev;
		logic [31:0] rdata;
		logic err;
		logic done;
		jlr_link_out_type out;
	} jlr_state_type;

	jlr_state_type st_q;
	jlr_state_type st_d;
	jlr_link_in_type lin_s;
	logic [11:0] reg_idx;
	logic addr_ok;
	logic access;
	logic [7:0] status_byte;
	logic [7:0] rd_byte;
	logic [7:0] fe_char;
	logic [7:0] id_even;
	logic sysref_rise;
	logic realign_rise;

	// ==========================================================
	// Elaboration checks
	// The index is taken as a fixed twelve-bit slice above the two byte-offset bits.
	if (JLR_ADDR_W != 14) begin
		$error("jlr_regs needs a 14-bit byte address.");
	end
	// Only byte lane 0 is returned, so every status field must sit in bits 7 to 0.
	if ((JLR_ST_LINK_UP > 7) || (JLR_ST_SYNC > 7) || (JLR_ST_REALIGNED > 7) ||
		(JLR_ST_MULTIFRAME_PHASE_SET_FLAG > 7) || (JLR_ST_PLL_LOCK > 7)) begin
		$error("jlr_regs status fields must lie in the low byte.");
	end
	// Two status fields on one bit would let a write-one clear hit the wrong flag.
	if ((JLR_ST_REALIGNED == JLR_ST_MULTIFRAME_PHASE_SET_FLAG) || (JLR_ST_LINK_UP == JLR_ST_SYNC) ||
		(JLR_ST_PLL_LOCK == JLR_ST_MULTIFRAME_PHASE_SET_FLAG) || (JLR_ST_PLL_LOCK == JLR_ST_REALIGNED)) begin
		$error("jlr_regs status fields must not overlap.");
	end
	// The control field is two bits wide, one bit each for enable and mode.
	if ((JLR_CTRL_ENABLE > 1) || (JLR_CTRL_64B66B > 1) || (JLR_CTRL_ENABLE == JLR_CTRL_64B66B)) begin
		$error("jlr_regs control bits must be bits 0 and 1.");
	end
	// An odd identifier after reset would read back with bit 0 set.
	if (JLR_RST_DEVICE_ID[0] != 1'b0) begin
		$error("jlr_regs identifier reset value must be even.");
	end
	// A reserved frame-end select after reset would start the link on an undefined comma.
	if (JLR_RST_FRAME_END == 2'h3) begin
		$error("jlr_regs frame-end reset select must not be the reserved code.");
	end
	// Two registers on one index would make the read decode ambiguous.
	if ((JLR_IDX_DEVICE_ID == JLR_IDX_FRAME_END) || (JLR_IDX_DEVICE_ID == JLR_IDX_STATUS) ||
		(JLR_IDX_DEVICE_ID == JLR_IDX_POWER_DOWN) || (JLR_IDX_DEVICE_ID == JLR_IDX_LINK_CTRL) ||
		(JLR_IDX_FRAME_END == JLR_IDX_STATUS) || (JLR_IDX_FRAME_END == JLR_IDX_POWER_DOWN) ||
		(JLR_IDX_FRAME_END == JLR_IDX_LINK_CTRL) || (JLR_IDX_STATUS == JLR_IDX_POWER_DOWN) ||
		(JLR_IDX_STATUS == JLR_IDX_LINK_CTRL) || (JLR_IDX_POWER_DOWN == JLR_IDX_LINK_CTRL)) begin
		$error("jlr_regs register indices must be distinct.");
	end

	// ==========================================================
	// Input synchronisers
	jlr_sync2 #(
		.WIDTH($bits(jlr_link_in_type))
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.async_in(link_in),
		.sync_out(lin_s)
	);

	// ==========================================================
	// Address decode
	assign reg_idx = paddr[JLR_ADDR_W-1:2];
	assign addr_ok = (paddr[1:0] == 2'h0) &&
		((reg_idx == JLR_IDX_DEVICE_ID) || (reg_idx == JLR_IDX_FRAME_END) ||
		(reg_idx == JLR_IDX_STATUS) || (reg_idx == JLR_IDX_POWER_DOWN) ||
		(reg_idx == JLR_IDX_LINK_CTRL));
	assign access = psel && penable && clk_en && !st_q.done;

	// ==========================================================
	// Link side views
	assign sysref_rise = lin_s.sysref_event && !st_q.sysref_prev;
	assign realign_rise = lin_s.sysref_realign && !st_q.realign_prev;

	always_comb begin
		status_byte = 8'h00;
		status_byte[JLR_ST_LINK_UP] = lin_s.link_up;
		status_byte[JLR_ST_SYNC] = lin_s.sync_n;
		status_byte[JLR_ST_REALIGNED] = st_q.realigned;
		status_byte[JLR_ST_MULTIFRAME_PHASE_SET_FLAG] = st_q.multiframe_phase_set_flag;
		status_byte[JLR_ST_PLL_LOCK] = lin_s.pll_locked;
	end

	always_comb begin
		case (jlr_fe_sel_type'(st_q.frame_end_sel))
			JLR_FE_K28_7: fe_char = JLR_K28_7;
			JLR_FE_K28_1: fe_char = JLR_K28_1;
			JLR_FE_K28_5: fe_char = JLR_K28_5;
			default: fe_char = JLR_K28_7;
		endcase
	end

	always_comb begin
		case (reg_idx)
			JLR_IDX_DEVICE_ID: rd_byte = st_q.device_id;
			JLR_IDX_FRAME_END: rd_byte = {6'h00, st_q.frame_end_sel};
			JLR_IDX_STATUS: rd_byte = status_byte;
			JLR_IDX_POWER_DOWN: rd_byte = {6'h00, st_q.power_down};
			JLR_IDX_LINK_CTRL: rd_byte = {6'h00, st_q.link_ctrl};
			default: rd_byte = 8'h00;
		endcase
	end

	assign id_even = {pwdata[7:1], 1'b0};

	// ==========================================================
	// Next state
	always_comb begin
		st_d = st_q;
		if (clk_en) begin
			st_d.done = access;
			st_d.err = 1'b0;
			st_d.sysref_prev = lin_s.sysref_event;
			st_d.realign_prev = lin_s.sysref_realign;
			if (!st_q.link_ctrl[JLR_CTRL_ENABLE]) begin
				st_d.armed = 1'b1;
			end
			if (access && pwrite && addr_ok && pstrb[0]) begin
				case (reg_idx)
					JLR_IDX_DEVICE_ID: st_d.device_id = id_even;
					JLR_IDX_FRAME_END: st_d.frame_end_sel = pwdata[1:0];
					JLR_IDX_POWER_DOWN: st_d.power_down = pwdata[1:0];
					JLR_IDX_LINK_CTRL: st_d.link_ctrl = pwdata[1:0];
					JLR_IDX_STATUS: begin
						if (pwdata[JLR_ST_REALIGNED]) begin
							st_d.realigned = 1'b0;
						end
						if (pwdata[JLR_ST_MULTIFRAME_PHASE_SET_FLAG]) begin
							st_d.multiframe_phase_set_flag = 1'b0;
						end
					end
					default: st_d.err = 1'b0;
				endcase
			end
			// realignment sets flag, set wins over clear
			if (realign_rise) begin
				st_d.realigned = 1'b1;
			end
			if (sysref_rise && st_q.link_ctrl[JLR_CTRL_ENABLE] && st_q.armed) begin
				st_d.multiframe_phase_set_flag = 1'b1;
				st_d.armed = 1'b0;
			end
			if (access) begin
				st_d.err = !addr_ok;
				st_d.rdata = (!pwrite && addr_ok) ? {24'h000000, rd_byte} : 32'h00000000;
			end
			st_d.out.device_id_a = st_q.device_id;
			// link B identifier is one higher
			st_d.out.device_id_b = st_q.device_id + 8'h01;
			st_d.out.frame_end_char = fe_char;
			// only 8b/10b modes use the comma
			// link logic substitutes it when a frame end allows
			st_d.out.frame_end_valid = !st_q.link_ctrl[JLR_CTRL_64B66B];
			st_d.out.link_enable = st_q.link_ctrl[JLR_CTRL_ENABLE];
			st_d.out.power_down = st_q.power_down;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.device_id <= JLR_RST_DEVICE_ID;
			st_q.frame_end_sel <= JLR_RST_FRAME_END;
			st_q.power_down <= JLR_RST_POWER_DOWN;
			st_q.link_ctrl <= JLR_RST_LINK_CTRL;
			st_q.out.frame_end_char <= JLR_K28_7;
			st_q.out.frame_end_valid <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	// Ready rises one cycle into the access phase so read data come from a register.
	assign pready = st_q.done;
	assign prdata = st_q.rdata;
	assign pslverr = st_q.err && st_q.done;
	assign link_out = st_q.out;
endmodule

// ---- inc/jlr_pkg.sv ----
// Package for the link identifier and status register group.
// Assumes a 32-bit APB slave on pclk with one register per 32-bit word.
package jlr_pkg;
	// ==========================================================
	// Register indices and byte address width
	localparam logic [11:0] JLR_IDX_DEVICE_ID = 12'h206;
	localparam logic [11:0] JLR_IDX_FRAME_END = 12'h207;
	localparam logic [11:0] JLR_IDX_STATUS = 12'h208;
	localparam logic [11:0] JLR_IDX_POWER_DOWN = 12'h209;
	localparam logic [11:0] JLR_IDX_LINK_CTRL = 12'h20f;
	localparam int JLR_ADDR_W = 14;
	// ==========================================================
	// Field positions
	localparam int JLR_ST_LINK_UP = 6;
	localparam int JLR_ST_SYNC = 5;
	localparam int JLR_ST_REALIGNED = 4;
	localparam int JLR_ST_MULTIFRAME_PHASE_SET_FLAG = 3;
	localparam int JLR_ST_PLL_LOCK = 2;
	localparam int JLR_CTRL_ENABLE = 0;
	localparam int JLR_CTRL_64B66B = 1;
	// ==========================================================
	// Reset values
	localparam logic [7:0] JLR_RST_DEVICE_ID = 8'h00;
	localparam logic [1:0] JLR_RST_FRAME_END = 2'h0;
	localparam logic [1:0] JLR_RST_POWER_DOWN = 2'h0;
	localparam logic [1:0] JLR_RST_LINK_CTRL = 2'h0;
	// ==========================================================
	// Comma encodings, 8b/10b code groups (byte only, K flag implied)
	localparam logic [7:0] JLR_K28_7 = 8'hfc;
	localparam logic [7:0] JLR_K28_1 = 8'h3c;
	localparam logic [7:0] JLR_K28_5 = 8'hbc;

	typedef enum logic [1:0] {
		JLR_FE_K28_7 = 2'b00,
		JLR_FE_K28_1 = 2'b01,
		JLR_FE_K28_5 = 2'b10,
		JLR_FE_RSVD = 2'b11
	} jlr_fe_sel_type;

	typedef struct packed {
		logic link_up;
		logic sync_n;
		logic sysref_realign;
		logic sysref_event;
		logic pll_locked;
	} jlr_link_in_type;

	typedef struct packed {
		logic [7:0] device_id_a;
		logic [7:0] device_id_b;
		logic [7:0] frame_end_char;
		logic frame_end_valid;
		logic link_enable;
		logic [1:0] power_down;
	} jlr_link_out_type;
endpackage

// ---- design/jlr_sync2.sv ----
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; no bus coherence is promised.
`timescale 1ns/1ns
module jlr_sync2 #(
	parameter int WIDTH = 5
) (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic clk_en, // Clock enable.
	input wire logic [WIDTH-1:0] async_in, // Asynchronous levels.
	output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} jlr_sync_state_type;

	jlr_sync_state_type st_q;
	jlr_sync_state_type st_d;

	// An empty group would leave the synchroniser with nothing to carry.
	if (WIDTH < 1) begin
		$error("jlr_sync2 needs WIDTH of at least one.");
	end

	always_comb begin
		st_d = st_q;
		if (clk_en) begin
			st_d.meta = async_in;
			st_d.sync = st_q.meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.sync;
endmodule

// ---- test/jlr_rx_model.sv ----
// Far-end receiver and link monitor model driving the status levels.
// Assumes the bench sets the wanted levels on pclk.
`timescale 1ns/1ns
module jlr_rx_model
	import jlr_pkg::*;
#(
	parameter int LAT = 3
) (
	input wire logic pclk, // clock
	input wire jlr_link_in_type want, // wanted levels
	output jlr_link_in_type link_in // levels to block
);
	// ==========
	// Delay line
	jlr_link_in_type [LAT-1:0] line_q;
	initial line_q = '0;
	always @(posedge pclk) begin
		line_q <= {line_q[LAT-2:0], want};
	end
	assign link_in = line_q[LAT-1];
endmodule

// ---- test/jlr_regs_props.sv ----
// Checker bound to jlr_regs.
// Assumes it sees only the ports of that module.
`timescale 1ns/1ns
module jlr_regs_props
	import jlr_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset
	input wire logic clk_en, // enable
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // write
	input wire logic [JLR_ADDR_W-1:0] paddr, // address
	input wire logic [31:0] pwdata, // data
	input wire logic [3:0] pstrb, // strobes
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire jlr_link_in_type link_in, // levels
	input wire jlr_link_out_type link_out // settings
);
	// ==========
	// Helpers
	logic w;
	logic r;
	logic [11:0] ix;
	logic [7:0] ev;
	jlr_link_in_type prev_q;
	logic [2:0] calm_q;
	assign w = psel && penable && pready && pwrite && pstrb[0];
	assign r = psel && penable && pready && !pwrite;
	assign ix = paddr[13:2];
	assign ev = {pwdata[7:1], 1'b0};
	// Status is only judged after the synchroniser lag has passed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
			calm_q <= 3'h0;
		end else begin
			prev_q <= link_in;
			calm_q <= (prev_q != link_in) ? 3'h0 : calm_q + {2'h0, calm_q != 3'h7};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// Properties
	property p_ida; w && ix == JLR_IDX_DEVICE_ID |-> ##[0:2] link_out.device_id_a == ev; endproperty
	a_ida: assert property (p_ida) else $error("id a");
	property p_idb; w && ix == JLR_IDX_DEVICE_ID |-> ##[0:2] link_out.device_id_b == ev + 8'h01; endproperty
	a_idb: assert property (p_idb) else $error("id b");
	property p_ide; link_out.device_id_a[0] == 1'b0; endproperty
	a_ide: assert property (p_ide) else $error("id odd");
	property p_idr; r && ix == JLR_IDX_DEVICE_ID |-> prdata[0] == 1'b0; endproperty
	a_idr: assert property (p_idr) else $error("id read");
	property p_fe; w && ix == JLR_IDX_FRAME_END |-> ##[0:2] link_out.frame_end_char ==
		(pwdata[1:0] == 2'h1 ? JLR_K28_1 : (pwdata[1:0] == 2'h2 ? JLR_K28_5 : JLR_K28_7)); endproperty
	a_fe: assert property (p_fe) else $error("comma");
	property p_md; w && ix == JLR_IDX_LINK_CTRL |-> ##[0:2] link_out.frame_end_valid == !pwdata[1]; endproperty
	a_md: assert property (p_md) else $error("mode");
	property p_up; r && ix == JLR_IDX_STATUS && calm_q > 3'h4 |-> prdata[JLR_ST_LINK_UP] == link_in.link_up; endproperty
	a_up: assert property (p_up) else $error("link up");
	property p_sy; r && ix == JLR_IDX_STATUS && calm_q > 3'h4 |-> prdata[JLR_ST_SYNC] == link_in.sync_n; endproperty
	a_sy: assert property (p_sy) else $error("sync");
	property p_pl; r && ix == JLR_IDX_STATUS && calm_q > 3'h4 |-> prdata[JLR_ST_PLL_LOCK] == link_in.pll_locked; endproperty
	a_pl: assert property (p_pl) else $error("pll");
endmodule
bind jlr_regs jlr_regs_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .link_in(link_in), .link_out(link_out));

// ---- test/jesd_link_id_status_regs_test.sv ----
// Self-checking bench for the identifier and status registers.
// Assumes the design, the far-end model and the checker are compiled.
`timescale 1ns/1ns
module jesd_link_id_status_regs_test
	import jlr_pkg::*;
;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err_q;
	logic [JLR_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	int fails, compares, cycles;
	jlr_link_in_type want, link_in;
	jlr_link_out_type link_out;
	jlr_rx_model u_rx (.pclk(pclk), .want(want), .link_in(link_in));
	jlr_regs DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_in(link_in), .link_out(link_out));
	// ==========
	// Tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] ix, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [11:0] ix, input logic [7:0] e);
		apb(1'b0, ix, 8'h00);
		check(rd[7:0], e);
	endtask
	task automatic t_id();
		rchk(JLR_IDX_DEVICE_ID, 8'h00);
		apb(1'b1, JLR_IDX_DEVICE_ID, 8'hff);
		rchk(JLR_IDX_DEVICE_ID, 8'hfe);
		check(link_out.device_id_a, 8'hfe);
		check(link_out.device_id_b, 8'hff);
	endtask
	task automatic t_fe();
		logic [7:0] k[4];
		k = '{JLR_K28_7, JLR_K28_1, JLR_K28_5, JLR_K28_7};
		check(link_out.frame_end_char, JLR_K28_7);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, JLR_IDX_FRAME_END, 8'(s));
			rchk(JLR_IDX_FRAME_END, 8'(s));
			check(link_out.frame_end_char, k[s]);
		end
		apb(1'b1, JLR_IDX_FRAME_END, 8'h00);
		check(link_out.frame_end_char, JLR_K28_7);
		apb(1'b1, JLR_IDX_POWER_DOWN, 8'h03);
		rchk(JLR_IDX_POWER_DOWN, 8'h03);
		check({6'h0, link_out.power_down}, 8'h03);
		apb(1'b1, JLR_IDX_LINK_CTRL, 8'h02);
		check({7'h0, link_out.frame_end_valid}, 8'h00);
		apb(1'b1, JLR_IDX_LINK_CTRL, 8'h00);
		check({7'h0, link_out.frame_end_valid}, 8'h01);
	endtask
	task automatic lv(input logic [4:0] v);
		want <= v;
		repeat (8) @(posedge pclk);
	endtask
	task automatic t_status();
		lv(5'b10001);
		rchk(JLR_IDX_STATUS, 8'h44);
		lv(5'b11101);
		lv(5'b11001);
		rchk(JLR_IDX_STATUS, 8'h74);
		apb(1'b1, JLR_IDX_STATUS, 8'h00);
		rchk(JLR_IDX_STATUS, 8'h74);
		apb(1'b1, JLR_IDX_STATUS, 8'h10);
		rchk(JLR_IDX_STATUS, 8'h64);
		apb(1'b1, JLR_IDX_LINK_CTRL, 8'h01);
		check({7'h0, link_out.link_enable}, 8'h01);
		lv(5'b11011);
		lv(5'b11001);
		rchk(JLR_IDX_STATUS, 8'h6c);
		apb(1'b1, JLR_IDX_STATUS, 8'h08);
		rchk(JLR_IDX_STATUS, 8'h64);
		lv(5'b11011);
		lv(5'b11001);
		rchk(JLR_IDX_STATUS, 8'h64);
		apb(1'b0, 12'h210, 8'h00);
		check({7'h0, err_q}, 8'h01);
	endtask
	// A realignment pulse that comes and goes while the clock enable is low must leave no trace.
	task automatic t_freeze();
		clk_en <= 1'b0;
		lv(5'b11101);
		lv(5'b11001);
		clk_en <= 1'b1;
		repeat (8) @(posedge pclk);
		rchk(JLR_IDX_STATUS, 8'h64);
	endtask
	task automatic print_verdict();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ==========
	// Clock, timeout and sequence
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		clk_en = 1'b1;
		want = '0;
		{fails, compares, cycles} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_id();
		t_fe();
		t_status();
		t_freeze();
		print_verdict();
	end
endmodule
